//--- verilog/stop_col_defines.svh
// register offsets, field positions, reset values and timing constants
// assumes inclusion by bare name from the design and bench files
`ifndef STOP_COL_DEFINES_SVH
`define STOP_COL_DEFINES_SVH

// ==========================================================
// register byte offsets
`define OFS_BUF 8'h00
`define OFS_RELOAD 8'h04
`define OFS_CON1 8'h08
`define OFS_CON2 8'h0C
`define OFS_STAT 8'h10
`define OFS_INT_STAT 8'h14
`define OFS_INT_CLR 8'h18
`define OFS_INT_EN 8'h1C

// ==========================================================
// field positions
`define CON1_WR_COL 7
`define CON1_SLAVE 6
`define CON1_MASKMODE 5
`define CON2_STOP_EN 2
`define CON2_RESTART_EN 1
`define CON2_START_EN 0
`define CON2_ACK_EN 4
`define STAT_STOP 4
`define INT_PORT 0
`define INT_COLL 1

// ==========================================================
// reset values
`define RELOAD_RST 8'h04
`define CON1_RST 8'h00
`define CON2_RST 8'h00

// ==========================================================
// timing
`define SYNC_STAGES 2

`endif

//--- verilog/stop_col_pkg.sv
// types shared by the stop-collision block
// assumes stop_col_defines.svh on the include path
package stop_col_pkg;
  // ==========================================================
  // stop sequence states, gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SDA_LOW = 3'b001,
    ST_SCL_REL = 3'b011,
    ST_TIME_HI = 3'b010,
    ST_SDA_REL = 3'b110,
    ST_TAIL = 3'b111
  } stop_state_e;

  // open-drain line pair as seen inward
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_s;

  // open-drain drive pair; oe high pulls the line low
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } bus_drive_s;
endpackage : stop_col_pkg

//--- verilog/line_sync.sv
// two-flop synchroniser for both bus lines
// assumes raw pin levels asynchronous to sys_clk_i
`timescale 1ns/1ps
module line_sync (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_n_i, // sync reset, low active
  input wire stop_col_pkg::bus_lines_s raw_i, // raw pins
  output stop_col_pkg::bus_lines_s sync_o // synchronised lines
);
  import stop_col_pkg::*;
  bus_lines_s meta_r; // first stage, read only by second
  // ==========================================================
  // two stages; bus idles high
  // two-flop synchroniser
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      meta_r <= 2'b11;
      sync_o <= 2'b11;
    end else begin
      meta_r <= raw_i;
      sync_o <= meta_r;
    end
  end
endmodule : line_sync

//--- verilog/rate_counter.sv
// bit-rate down counter, loads seven reload bits
// assumes load and clear from same-clock logic
`timescale 1ns/1ps
module rate_counter (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_n_i, // sync reset, low active
  input wire logic load_i, // load reload value
  input wire logic clear_i, // stop counting
  input wire logic [6:0] reload_i, // reload value
  output logic expire_o // one-cycle pulse at zero
);
  logic [6:0] cnt_r; // remaining count
  logic run_r; // counting
  // ==========================================================
  // load then count down
  // load ignored while running, so a held load restarts it only after each expiry
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= 7'h00;
      run_r <= 1'b0;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (clear_i) begin
        run_r <= 1'b0;
      end else if (load_i && !run_r) begin
        cnt_r <= reload_i;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r == 7'h00) begin
          run_r <= 1'b0;
          expire_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 7'h01;
        end
      end
    end
  end
endmodule : rate_counter

//--- verilog/stop_collision.sv
// i2c master stop sequence with bus collision detection, axi4-lite regs
// assumes open-drain lines resolved outside; pins asynchronous
//
// Contract
// - data low after timeout flags collision
// - clock low after being seen high, before data release, flags collision
// - stop starts driving data low, clock low
// - release clock only after data seen low
// - clock high loads counter from reload[6:0]
// - timeout samples data line for collision
// - mask shares reload address, slave mask mode
// - slave mode: control two holds mask bits
// - stop seen, then pen clear, port event
// - collision sets flag, returns to idle
// - collision aborts sequence, clears controls, releases
// - buffer write during stop sets write collision
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "stop_col_defines.svh"
module stop_collision (
  input wire logic sys_clk_i, // system clock, 200 MHz
  input wire logic rst_n_i, // sync reset, low active
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire stop_col_pkg::bus_lines_s line_i, // raw line levels
  output stop_col_pkg::bus_drive_s drive_o, // line pull-down enables
  output logic irq_o // level interrupt
);
  import stop_col_pkg::*;

  // ==========================================================
  // declarations
  bus_lines_s line_s; // synchronised lines
  stop_state_e state_r; // stop sequence state
  logic [7:0] buf_r; // transfer buffer
  logic [7:0] reload_r; // reload value register
  logic [7:0] mask_r; // address mask register
  logic [7:0] con1_r; // control one
  logic [7:0] con2_r; // control two
  logic [7:0] mask2_r; // slave mask bits of control two
  logic stop_seen_r; // stop-seen status
  logic [1:0] int_stat_r; // sticky events
  logic [1:0] int_en_r; // event enables
  logic cnt_load; // counter load
  logic cnt_clear; // counter abort
  logic cnt_expire; // counter timeout
  logic coll; // collision this cycle
  logic stop_done; // stop finished
  logic [7:0] aw_addr_r; // captured write address
  logic aw_have_r; // write address held
  logic [31:0] w_data_r; // captured write data
  logic [3:0] w_strb_r; // captured strobes
  logic w_have_r; // write data held
  logic wr_go; // perform write
  logic wr_ok; // write address mapped
  logic [7:0] wbyte; // low byte written

  // decode for mapped offsets, used by both channels
  function automatic logic mapped(input logic [7:0] a);
    if (a == `OFS_BUF) mapped = 1'b1;
    else if (a == `OFS_RELOAD) mapped = 1'b1;
    else if (a == `OFS_CON1) mapped = 1'b1;
    else if (a == `OFS_CON2) mapped = 1'b1;
    else if (a == `OFS_STAT) mapped = 1'b1;
    else if (a == `OFS_INT_STAT) mapped = 1'b1;
    else if (a == `OFS_INT_CLR) mapped = 1'b1;
    else if (a == `OFS_INT_EN) mapped = 1'b1;
    else mapped = 1'b0;
  endfunction : mapped

  // mask register reachable only in slave mask mode
  function automatic logic mask_sel(input logic [7:0] c1);
    mask_sel = c1[`CON1_SLAVE] & c1[`CON1_MASKMODE];
  endfunction : mask_sel

  // ==========================================================
  // submodules
  line_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .raw_i(line_i),
    .sync_o(line_s)
  );

  rate_counter u_cnt (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(cnt_load),
    .clear_i(cnt_clear),
    .reload_i(reload_r[6:0]),
    .expire_o(cnt_expire)
  );

  // ==========================================================
  // stop sequence combinational events
  always_comb begin
    cnt_load = 1'b0;
    coll = 1'b0;
    stop_done = 1'b0;
    case (state_r)
      ST_SDA_LOW: begin
        cnt_load = ~line_s.sda & ~cnt_expire;
      end
      ST_SCL_REL: begin
        cnt_load = line_s.scl;
      end
      ST_TIME_HI: begin
        coll = ~line_s.scl;
        cnt_load = cnt_expire & line_s.scl;
      end
      ST_SDA_REL: begin
        coll = cnt_expire & ~line_s.sda;
        cnt_load = cnt_expire & line_s.sda;
      end
      ST_TAIL: begin
        stop_done = cnt_expire;
      end
      default: begin
        cnt_load = 1'b0;
      end
    endcase
  end
  assign cnt_clear = coll;

  // ==========================================================
  // stop sequence state and line drive
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      drive_o <= 2'b00;
    end else if (coll) begin
      state_r <= ST_IDLE;
      drive_o <= 2'b00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (con2_r[`CON2_STOP_EN] && !con1_r[`CON1_SLAVE]) begin
            state_r <= ST_SDA_LOW;
            drive_o <= 2'b11;
          end
        end
        ST_SDA_LOW: begin
          // wait counter period then release clock
          if (cnt_expire) begin
            state_r <= ST_SCL_REL;
            drive_o.scl_oe <= 1'b0;
          end
        end
        ST_SCL_REL: begin
          if (line_s.scl) state_r <= ST_TIME_HI;
        end
        ST_TIME_HI: begin
          if (cnt_expire) begin
            state_r <= ST_SDA_REL;
            drive_o.sda_oe <= 1'b0;
          end
        end
        ST_SDA_REL: begin
          if (cnt_expire) state_r <= ST_TAIL;
        end
        ST_TAIL: begin
          if (stop_done) state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // stop-seen status
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      stop_seen_r <= 1'b0;
    end else if (state_r == ST_SDA_REL && cnt_expire && line_s.sda &&
                 line_s.scl) begin
      stop_seen_r <= 1'b1;
    end else if (state_r == ST_SDA_LOW) begin
      stop_seen_r <= 1'b0;
    end
  end

  // ==========================================================
  // axi write channel capture
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
    end
  end
  assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wr_ok = mapped(aw_addr_r);
  assign wbyte = w_data_r[7:0];

  // ready and write response
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= ~aw_have_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_have_r & ~(s_axi_wvalid & s_axi_wready);
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // buffer, reload and mask registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      buf_r <= 8'h00;
      reload_r <= `RELOAD_RST;
      mask_r <= 8'hFF;
    end else if (wr_go && w_strb_r[0]) begin
      if (aw_addr_r == `OFS_BUF && state_r == ST_IDLE &&
          !con2_r[`CON2_STOP_EN]) begin
        buf_r <= wbyte;
      // shared address, mask in slave mask mode
      end else if (aw_addr_r == `OFS_RELOAD && mask_sel(con1_r)) begin
        mask_r <= wbyte;
      end else if (aw_addr_r == `OFS_RELOAD) begin
        reload_r <= wbyte;
      end
    end
  end

  // control one, write collision is set-wins
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      con1_r <= `CON1_RST;
    end else begin
      if (wr_go && w_strb_r[0] && aw_addr_r == `OFS_CON1) begin
        con1_r <= wbyte;
      end
      if (wr_go && w_strb_r[0] && aw_addr_r == `OFS_BUF &&
          (state_r != ST_IDLE || con2_r[`CON2_STOP_EN])) begin
        con1_r[`CON1_WR_COL] <= 1'b1;
      end
    end
  end

  // control two; sequence bits cleared by hardware
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      con2_r <= `CON2_RST;
      mask2_r <= 8'h00;
    end else begin
      if (wr_go && w_strb_r[0] && aw_addr_r == `OFS_CON2) begin
        // slave mode takes middle bits as mask
        if (con1_r[`CON1_SLAVE]) begin
          mask2_r <= wbyte;
          con2_r[7] <= wbyte[7];
          con2_r[0] <= wbyte[0];
        end else begin
          con2_r <= wbyte;
        end
      end
      if (coll) begin
        con2_r[`CON2_STOP_EN] <= 1'b0;
        con2_r[`CON2_RESTART_EN] <= 1'b0;
        con2_r[`CON2_START_EN] <= 1'b0;
        con2_r[`CON2_ACK_EN] <= 1'b0;
      end
      if (stop_done) con2_r[`CON2_STOP_EN] <= 1'b0;
    end
  end

  // ==========================================================
  // interrupt status, enable, clear; set wins over clear
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      int_stat_r <= 2'b00;
      int_en_r <= 2'b00;
    end else begin
      if (wr_go && w_strb_r[0] && aw_addr_r == `OFS_INT_EN) begin
        int_en_r <= wbyte[1:0];
      end
      if (wr_go && w_strb_r[0] && aw_addr_r == `OFS_INT_CLR) begin
        int_stat_r <= int_stat_r & ~wbyte[1:0];
      end
      if (stop_done) int_stat_r[`INT_PORT] <= 1'b1;
      if (coll) int_stat_r[`INT_COLL] <= 1'b1;
    end
  end

  // level interrupt from a flop
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) irq_o <= 1'b0;
    else irq_o <= |(int_stat_r & int_en_r);
  end

  // ==========================================================
  // axi read channel, one cycle after address
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
        if (s_axi_araddr == `OFS_BUF) s_axi_rdata <= {24'h0, buf_r};
        else if (s_axi_araddr == `OFS_RELOAD)
          s_axi_rdata <= {24'h0, mask_sel(con1_r) ? mask_r : reload_r};
        else if (s_axi_araddr == `OFS_CON1) s_axi_rdata <= {24'h0, con1_r};
        else if (s_axi_araddr == `OFS_CON2)
          s_axi_rdata <= {24'h0, con1_r[`CON1_SLAVE] ?
                          {con2_r[7:6], mask2_r[5:1], con2_r[0]} : con2_r};
        else if (s_axi_araddr == `OFS_STAT)
          s_axi_rdata <= {27'h0, stop_seen_r, 4'h0};
        else if (s_axi_araddr == `OFS_INT_STAT)
          s_axi_rdata <= {30'h0, int_stat_r};
        else if (s_axi_araddr == `OFS_INT_EN)
          s_axi_rdata <= {30'h0, int_en_r};
        else s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : stop_collision

//--- tb/stop_col_chk.sv
// checker for the stop sequence and axi answers
// assumes bind onto the stop_collision top ports
`timescale 1ns/1ps
module stop_col_chk (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_n_i, // sync reset, low active
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire stop_col_pkg::bus_lines_s line_i, // bus lines
  input wire stop_col_pkg::bus_drive_s drive_o // pull-downs
);
  import stop_col_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // sequences
  // clock released and seen high, data still held
  sequence clk_up_s;
    (drive_o == 2'b01 && line_i.scl) [*3];
  endsequence
  // clock pulled low by someone else
  sequence clk_lost_s;
    (drive_o == 2'b01 && !line_i.scl) [*3];
  endsequence
  // ==========================================================
  // assertions
  AST_STOP_OPEN: assert property (
    $rose(drive_o.sda_oe) |-> drive_o.scl_oe)
    else $error("stop opened with clock released");
  AST_CLK_REL: assert property (
    $fell(drive_o.scl_oe) && drive_o.sda_oe |-> $past(!line_i.sda, 3))
    else $error("clock released before data seen low");
  AST_CLK_LOST: assert property (
    clk_up_s ##1 clk_lost_s |-> ##[0:4] drive_o == 2'b00)
    else $error("lost clock not aborted");
  AST_SYNC_LAG: assert property (
    drive_o == 2'b01 && $fell(line_i.scl) |=> drive_o == 2'b01)
    else $error("raw line used unsynchronised");
  AST_DATA_LAST: assert property (
    $fell(drive_o.sda_oe) |-> !drive_o.scl_oe)
    else $error("data released before clock");
  AST_R_NEXT: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_R_CODE: assert property (
    s_axi_rvalid |-> s_axi_rresp inside {2'b00, 2'b10})
    else $error("bad read response code");
  AST_R_UPPER: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
endmodule : stop_col_chk

bind stop_collision stop_col_chk u_chk (.sys_clk_i, .rst_n_i,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
  .line_i, .drive_o);

//--- tb/i2c_bus_model.sv
// open-drain bus with pull-ups and one more master or slave
// assumes the bench commands when the other party pulls
`timescale 1ns/1ps
module i2c_bus_model (
  input wire stop_col_pkg::bus_drive_s drive_i, // dut pull-downs
  input wire logic hold_scl_i, // other party stretches clock
  input wire logic hold_sda_i, // other party forces data zero
  output stop_col_pkg::bus_lines_s line_o // resolved lines
);
  import stop_col_pkg::*;
  // wired and; released lines go high through pull-ups
  assign line_o.scl = !(drive_i.scl_oe || hold_scl_i);
  assign line_o.sda = !(drive_i.sda_oe || hold_sda_i);
endmodule : i2c_bus_model

//--- tb/stop_collision_tb.sv
// self-checking bench for the stop-collision block
// assumes checker and bus model compiled before it
`timescale 1ns/1ps
`include "stop_col_defines.svh"
module stop_collision_tb;
  import stop_col_pkg::*;
  // ==========================================================
  // signals
  logic sys_clk_i, rst_n_i; // clock, reset
  logic [7:0] awaddr, araddr; // addresses
  logic [31:0] wdata, rdata, rd, seed; // data, read copy, rng
  logic [3:0] strb; // write strobes
  logic awvalid, wvalid, bready, arvalid, rready; // master side
  logic awready, wready, bvalid, arready, rvalid, irq; // slave side
  logic [1:0] bresp, rresp, rsp; // responses
  logic hold_scl, hold_sda; // other party pulls
  bus_lines_s line; // resolved lines
  bus_drive_s drive; // dut pull-downs
  int fails, samples_checked; // counters

  stop_collision DUT (.sys_clk_i, .rst_n_i, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .line_i(line), .drive_o(drive), .irq_o(irq));
  i2c_bus_model u_bus (.drive_i(drive), .hold_scl_i(hold_scl),
    .hold_sda_i(hold_sda), .line_o(line));

  // 200 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs
  // counter period comes from seven reload bits
  function automatic int lo7(input logic [7:0] v);
    return int'(v[6:0]);
  endfunction : lo7
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task give_verdict;
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // a wait ran out
  task stall;
    fails++;
    give_verdict();
  endtask : stall
  // axi write, both channels offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge sys_clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rsp = bresp;
    bready <= 1'b0;
    if (i == 100) stall();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    int i;
    @(posedge sys_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge sys_clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (i == 100) stall();
  endtask : axi_rd
  // read until a bit shows the wanted level
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int i;
    for (i = 0; i < 60; i++) begin
      axi_rd(a);
      if (rd[b] === v) break;
    end
    if (i == 60) stall();
  endtask : poll
  // cycles until the pull-downs reach a pattern
  task automatic wait_drv(input logic [1:0] d, output int n);
    for (n = 0; n < 2000 && drive !== d; n++) @(posedge sys_clk_i);
    if (n == 2000) stall();
  endtask : wait_drv
  task automatic start_stop(input logic [7:0] rl, output int n);
    axi_wr(`OFS_RELOAD, rl);
    axi_wr(`OFS_CON2, 8'h04);
    wait_drv(2'b01, n);
  endtask : start_stop
  // collision aftermath
  task automatic after_col;
    poll(`OFS_INT_STAT, `INT_COLL, 1'b1);
    axi_rd(`OFS_CON2);
    check(rd & 8'h17, 0);
    check(drive, 2'b00);
  endtask : after_col
  // ==========================================================
  // main sequence
  initial begin : main
    int n, k;
    logic [7:0] rl;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {hold_scl, hold_sda} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    strb = 4'hF;
    fails = 0;
    samples_checked = 0;
    seed = 32'h9D311057;
    rst_n_i = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    // reset values, unmapped and refused accesses
    axi_rd(`OFS_RELOAD);
    check(rd, `RELOAD_RST);
    axi_rd(`OFS_CON1);
    check(rd, `CON1_RST);
    axi_rd(`OFS_CON2);
    check(rd, `CON2_RST);
    axi_rd(8'h20);
    check({rsp, rd[7:0]}, 10'h200);
    axi_wr(8'h24, 1);
    check(rsp, 2'b10);
    strb <= 4'hE;
    axi_wr(`OFS_RELOAD, 8'h33);
    strb <= 4'hF;
    axi_wr(`OFS_INT_STAT, 3);
    axi_rd(`OFS_RELOAD);
    check(rd, `RELOAD_RST);
    axi_rd(`OFS_INT_STAT);
    check(rd, 0);
    axi_wr(`OFS_INT_EN, 3);
    axi_wr(`OFS_BUF, 8'h3C);
    // good stops, reload 8'h81 then random reloads, one with clock stretching
    for (k = 0; k < 4; k++) begin
      seed = xs(seed);
      // a zero reload ends before released data clears the synchroniser
      rl = (k == 0) ? 8'h81 : ((seed[7:0] & 8'h9F) | 8'h01);
      hold_scl <= (k == 1);
      start_stop(rl, n);
      if (k == 1) begin
        axi_wr(`OFS_BUF, 8'h5A);
        repeat (20) @(posedge sys_clk_i);
        check(drive, 2'b01);
        hold_scl <= 1'b0;
      end
      wait_drv(2'b00, n);
      check(n >= lo7(rl) + 2 && n <= lo7(rl) + 8, 1);
      poll(`OFS_CON2, `CON2_STOP_EN, 1'b0);
      axi_rd(`OFS_STAT);
      check(rd[`STAT_STOP], 1);
      check(irq, 1);
      axi_rd(`OFS_INT_STAT);
      check(rd[1:0], 2'b01);
      axi_wr(`OFS_INT_CLR, 1);
      axi_rd(`OFS_INT_STAT);
      check({rd[1:0], irq}, 3'b000);
    end
    axi_rd(`OFS_BUF);
    check(rd, 8'h3C);
    axi_rd(`OFS_CON1);
    check(rd[`CON1_WR_COL], 1);
    axi_wr(`OFS_CON1, 0);
    // data forced low by another master
    hold_sda <= 1'b1;
    start_stop(8'h08, n);
    wait_drv(2'b00, n);
    after_col();
    hold_sda <= 1'b0;
    axi_wr(`OFS_INT_CLR, 2);
    // clock pulled low in mid-period
    start_stop(8'h30, n);
    repeat (10) @(posedge sys_clk_i);
    hold_scl <= 1'b1;
    wait_drv(2'b00, n);
    check(n <= 6, 1);
    after_col();
    hold_scl <= 1'b0;
    // mask and re-enable the interrupt
    axi_wr(`OFS_INT_EN, 0);
    axi_rd(`OFS_INT_STAT);
    check({rd[1], irq}, 2'b10);
    axi_wr(`OFS_INT_EN, 2);
    axi_rd(`OFS_INT_STAT);
    check(irq, 1);
    // slave mode: mask shares the reload place
    axi_wr(`OFS_CON1, 8'h60);
    axi_rd(`OFS_RELOAD);
    check(rd, 8'hFF);
    axi_wr(`OFS_RELOAD, 8'h3C);
    axi_rd(`OFS_RELOAD);
    check(rd, 8'h3C);
    axi_wr(`OFS_CON1, 8'h40);
    axi_rd(`OFS_RELOAD);
    check(rd, 8'h30);
    axi_wr(`OFS_CON2, 8'h3E);
    axi_rd(`OFS_CON2);
    check({rd, drive}, 34'h0F8);
    give_verdict();
  end
endmodule : stop_collision_tb
